// [rtl/usb_irq_consts.svh]
// constants for the usb device interrupt logic
`ifndef USB_IRQ_CONSTS_SVH
`define USB_IRQ_CONSTS_SVH

// ---------------------------------------------------------------
// command codes and transfer length
// ---------------------------------------------------------------
`define CMD_READ_IRQ 8'hC0
`define IRQ_READ_BYTES 2'h3

// ---------------------------------------------------------------
// source register bit positions
// ---------------------------------------------------------------
`define BIT_BUS_RESET 0
`define BIT_RESUME 1
`define BIT_SLEEP_ENTRY 2
`define BIT_TRANSFER_DONE 3
`define BIT_FRAME 4
`define BIT_PSEUDO_FRAME 5
`define BIT_BUS_SLEEP 7
`define BIT_CTRL_OUT 8
`define BIT_CTRL_IN 9
`define BIT_EP_FIRST 10
`define NUM_EP 14
`define NUM_SRC 24

// read clears these latched flags
`define READ_CLEAR_MASK 32'h0000001B
// reserved bits never read as one
`define SRC_VALID_MASK 32'h00FFFFBF

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_HZ 20000000
`define FRAME_US 1000
`define FRAME_CYCLES ((`CLK_HZ / 1000000) * `FRAME_US)
`define PULSE_NS 166
// least time: round up
`define PULSE_CYCLES ((`PULSE_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define MISSED_FOR_SLEEP 2'h3

`endif

// [rtl/usb_irq_pkg.sv]
// types for the usb device interrupt logic
package usb_irq_pkg;
    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_DATA = 2'b01
    } rd_state_t;

    typedef struct packed {
        rd_state_t rd_state;
        logic [1:0] byte_idx;
        logic [31:0] snap;
        logic [7:0] rd_data;
        logic [23:0] src;
        logic [31:0] enable;
        logic global_en;
        logic polarity_high;
        logic pulse_style;
        logic [14:0] frame_cnt;
        logic [1:0] missed;
        logic frame_seen;
        logic bus_asleep;
        logic sleep_req;
        logic any_prev;
        logic [2:0] pulse_cnt;
        logic irq_pin;
    } state_t;
endpackage

// [rtl/usb_irq_logic.sv]
// interrupt source, gating and output logic of a full-speed usb device
`include "usb_irq_consts.svh"

// Summary of operation
// - flag per programmable endpoint 1 to 14
// - separate control IN and OUT flags
// - bus sleep bit follows live bus
// - pseudo frame flag every 1 ms once a real frame is seen, until suspend
// - three missed frames enter suspend
// - own enable for pseudo frame interrupt
// - frame flag on detected start of frame
// - transfer done flag on counter zero
// - sleep entry flag on awake to suspend
// - resume flag on resume signalling
// - bus reset flag on bus reset
// - always log; enables gate the request
// - global enable blocks the output
// - polarity and style; default low, level
// - pulse of at least 166 ns (4 cycles, 200 ns) on rising OR
// - source read clears six event flags
// - endpoint flag cleared by status read
// - setup/out flag after data acknowledged
// - bulk flag on every ack
// - iso flag on every transaction
module usb_irq_logic (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // command interface (same clock domain)
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic data_rd,
    output logic [7:0] data_out,
    // configuration writes
    input wire logic enable_wr,
    input wire logic [31:0] enable_wdata,
    input wire logic mode_wr,
    input wire logic global_irq_enable,
    input wire logic hwcfg_wr,
    input wire logic irq_polarity_select,
    input wire logic irq_signal_style,
    // endpoint events and status reads
    input wire logic [13:0] ep_event,
    input wire logic [13:0] ep_status_rd,
    input wire logic ctrl_in_event,
    input wire logic ctrl_out_event,
    input wire logic ctrl_in_status_rd,
    input wire logic ctrl_out_status_rd,
    // bus events from the serial engine
    input wire logic frame_seen_pulse,
    input wire logic bus_reset_pulse,
    input wire logic resume_pulse,
    input wire logic dma_count_zero,
    input wire logic bus_idle_level,
    // outputs
    output logic irq_out,
    output logic bus_sleep_state,
    output logic sleep_request
);

    usb_irq_pkg::state_t s_q;
    usb_irq_pkg::state_t s_d;

    // ---------------------------------------------------------------
    // idle-line input synchroniser, three stages
    // ---------------------------------------------------------------
    logic [2:0] idle_sync_q;

    // the bus idle level comes from the transceiver domain
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            idle_sync_q <= 3'h0;
        end else begin
            idle_sync_q <= {idle_sync_q[1:0], bus_idle_level};
        end
    end

    // ---------------------------------------------------------------
    // event vector assembly
    // ---------------------------------------------------------------
    logic [23:0] set_vec;
    logic [23:0] clr_vec;
    logic [31:0] src_full;
    logic any_req;
    logic read_start;
    logic read_last;
    logic sleep_now;
    logic pseudo_tick;
    // endpoint vectors kept apart so set_vec and clr_vec have one writer each
    logic [`NUM_EP-1:0] ep_set;
    logic [`NUM_EP-1:0] ep_clr;

    assign read_start = cmd_valid && (cmd_code == `CMD_READ_IRQ);
    assign read_last = (s_q.rd_state == usb_irq_pkg::RD_DATA) && data_rd
        && (s_q.byte_idx == `IRQ_READ_BYTES);
    assign src_full = {8'h00, s_q.src} & `SRC_VALID_MASK;

    // endpoint flags: the caller pulses ep_event after acking data,
    // on every bulk ack and on every iso transaction
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_EP; gi = gi + 1) begin : g_ep
            assign ep_set[gi] = ep_event[gi];
            assign ep_clr[gi] = ep_status_rd[gi];
        end
    endgenerate

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // live bus status once the last two stages agree
        if (idle_sync_q[2] == idle_sync_q[1]) begin
            s_d.bus_asleep = idle_sync_q[2] | s_q.sleep_req;
        end
        // frame timer: restart on a real frame, else tick every 1 ms
        pseudo_tick = 1'b0;
        if (frame_seen_pulse) begin
            s_d.frame_cnt = 15'h0000;
            s_d.missed = 2'h0;
            s_d.sleep_req = 1'b0;
            s_d.frame_seen = 1'b1;
        end else if (s_q.frame_cnt == 15'(`FRAME_CYCLES - 1)) begin
            s_d.frame_cnt = 15'h0000;
            pseudo_tick = s_q.frame_seen;
            if (s_q.frame_seen && s_q.missed != `MISSED_FOR_SLEEP) begin
                s_d.missed = s_q.missed + 2'h1;
            end
        end else begin
            s_d.frame_cnt = s_q.frame_cnt + 15'h0001;
        end
        if (s_d.missed == `MISSED_FOR_SLEEP) begin
            s_d.sleep_req = 1'b1;
            s_d.frame_seen = 1'b0;
        end
        if (bus_reset_pulse || resume_pulse) begin
            s_d.sleep_req = 1'b0;
            s_d.missed = 2'h0;
        end
        sleep_now = s_d.bus_asleep && !s_q.bus_asleep;

        // set and clear vectors for the non-endpoint flags
        set_vec[7:0] = 8'h00;
        clr_vec[7:0] = 8'h00;
        set_vec[`BIT_BUS_RESET] = bus_reset_pulse;
        set_vec[`BIT_RESUME] = resume_pulse;
        set_vec[`BIT_SLEEP_ENTRY] = sleep_now;
        set_vec[`BIT_TRANSFER_DONE] = dma_count_zero;
        set_vec[`BIT_FRAME] = frame_seen_pulse;
        set_vec[`BIT_PSEUDO_FRAME] = pseudo_tick;
        if (read_last) begin
            clr_vec[7:0] = 8'(`READ_CLEAR_MASK);
        end
        // sleep entry and pseudo frame also clear on every completed source read
        if (read_last) begin
            clr_vec[`BIT_SLEEP_ENTRY] = 1'b1;
            clr_vec[`BIT_PSEUDO_FRAME] = 1'b1;
        end
        set_vec[`BIT_CTRL_OUT] = ctrl_out_event;
        set_vec[`BIT_CTRL_IN] = ctrl_in_event;
        clr_vec[`BIT_CTRL_OUT] = ctrl_out_status_rd;
        clr_vec[`BIT_CTRL_IN] = ctrl_in_status_rd;
        set_vec[`BIT_EP_FIRST +: `NUM_EP] = ep_set;
        clr_vec[`BIT_EP_FIRST +: `NUM_EP] = ep_clr;

        // set beats clear so no event is lost; always logged
        s_d.src = (s_q.src & ~clr_vec) | set_vec;
        s_d.src[`BIT_BUS_SLEEP] = s_d.bus_asleep;

        // four-byte read sequencer, snapshot taken at command
        case (s_q.rd_state)
            usb_irq_pkg::RD_IDLE: begin
                if (read_start) begin
                    s_d.rd_state = usb_irq_pkg::RD_DATA;
                    s_d.byte_idx = 2'h0;
                    s_d.snap = src_full;
                    s_d.rd_data = src_full[7:0];
                end
            end
            usb_irq_pkg::RD_DATA: begin
                if (data_rd) begin
                    s_d.byte_idx = s_q.byte_idx + 2'h1;
                    s_d.rd_data = s_q.snap[8 * (s_q.byte_idx + 2'h1) +: 8];
                    if (read_last) begin
                        s_d.rd_state = usb_irq_pkg::RD_IDLE;
                        s_d.rd_data = 8'h00;
                    end
                end
            end
            default: begin
                s_d.rd_state = usb_irq_pkg::RD_IDLE;
            end
        endcase

        // configuration writes
        if (enable_wr) begin
            s_d.enable = enable_wdata;
        end
        if (mode_wr) begin
            s_d.global_en = global_irq_enable;
        end
        if (hwcfg_wr) begin
            s_d.polarity_high = irq_polarity_select;
            s_d.pulse_style = irq_signal_style;
        end

        // gated request: per-bit enables, then global enable
        any_req = s_q.global_en && |(src_full & s_q.enable);
        s_d.any_prev = any_req;
        if (s_q.pulse_cnt != 3'h0) begin
            s_d.pulse_cnt = s_q.pulse_cnt - 3'h1;
        end else if (s_q.pulse_style && any_req && !s_q.any_prev) begin
            s_d.pulse_cnt = 3'(`PULSE_CYCLES);
        end
        if (s_q.pulse_style) begin
            s_d.irq_pin = (s_d.pulse_cnt != 3'h0) ~^ s_q.polarity_high;
        end else begin
            s_d.irq_pin = any_req ~^ s_q.polarity_high;
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    // reset defaults: active low, level style, output idle high
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '0;
            s_q.irq_pin <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign data_out = s_q.rd_data;
    assign irq_out = s_q.irq_pin;
    assign bus_sleep_state = s_q.bus_asleep;
    assign sleep_request = s_q.sleep_req;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    a_level_follows_req: assert property (@(posedge clk) disable iff (sys_rst)
        !s_q.pulse_style && !$past(s_q.pulse_style) && $stable(s_q.polarity_high)
        |-> irq_out == ($past(s_q.global_en && |(src_full & s_q.enable)) ~^ s_q.polarity_high))
        else $error("level output does not follow request");
    a_global_blocks: assert property (@(posedge clk) disable iff (sys_rst)
        !s_q.global_en && !s_q.pulse_style ##1 !s_q.pulse_style && $stable(s_q.polarity_high)
        |-> irq_out == !s_q.polarity_high)
        else $error("global disable did not block output");
    a_pulse_width: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(s_q.pulse_cnt != 3'h0) |-> (s_q.pulse_cnt != 3'h0) [*4] ##1 s_q.pulse_cnt == 3'h0)
        else $error("pulse width wrong");
    a_read_clears: assert property (@(posedge clk) disable iff (sys_rst)
        read_last && !bus_reset_pulse |=> !s_q.src[`BIT_BUS_RESET])
        else $error("bus reset flag survived read");
    a_ep_kept: assert property (@(posedge clk) disable iff (sys_rst)
        read_last && s_q.src[`BIT_EP_FIRST] && !ep_status_rd[0] |=> s_q.src[`BIT_EP_FIRST])
        else $error("endpoint flag cleared by source read");
    a_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
        ep_event[0] |=> s_q.src[`BIT_EP_FIRST])
        else $error("endpoint event lost");
    a_frame_flag: assert property (@(posedge clk) disable iff (sys_rst)
        frame_seen_pulse |=> s_q.src[`BIT_FRAME] && s_q.frame_cnt == 15'h0000)
        else $error("frame flag not set");
    a_sleep_entry: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(s_q.bus_asleep) |-> s_q.src[`BIT_SLEEP_ENTRY])
        else $error("sleep entry flag missing");
    a_missed_sleep: assert property (@(posedge clk) disable iff (sys_rst)
        s_q.missed == `MISSED_FOR_SLEEP |-> s_q.sleep_req)
        else $error("no suspend after missed frames");
    // pseudo tick always lands in its flag
    a_pseudo_flag: assert property (@(posedge clk) disable iff (sys_rst)
        pseudo_tick |=> s_q.src[`BIT_PSEUDO_FRAME])
        else $error("pseudo frame flag not set");
    // frame timer wraps at one frame
    a_frame_timer: assert property (@(posedge clk) disable iff (sys_rst)
        s_q.frame_cnt <= 15'(`FRAME_CYCLES - 1))
        else $error("frame timer out of range");
    // enabled pseudo flag raises the request
    a_pseudo_gate: assert property (@(posedge clk) disable iff (sys_rst)
        s_q.global_en && s_q.enable[`BIT_PSEUDO_FRAME] && s_q.src[`BIT_PSEUDO_FRAME] |-> any_req)
        else $error("pseudo frame enable ignored");
    // bus sleep bit is live, never latched
    a_bus_sleep_bit: assert property (@(posedge clk) disable iff (sys_rst)
        s_q.src[`BIT_BUS_SLEEP] == s_q.bus_asleep)
        else $error("bus sleep bit differs from bus state");
    // transfer done event is logged
    a_done_flag: assert property (@(posedge clk) disable iff (sys_rst)
        dma_count_zero |=> s_q.src[`BIT_TRANSFER_DONE])
        else $error("transfer done flag not set");
    // resume event is logged
    a_resume_flag: assert property (@(posedge clk) disable iff (sys_rst)
        resume_pulse |=> s_q.src[`BIT_RESUME])
        else $error("resume flag not set");
    // bus reset event is logged
    a_reset_flag: assert property (@(posedge clk) disable iff (sys_rst)
        bus_reset_pulse |=> s_q.src[`BIT_BUS_RESET])
        else $error("bus reset flag not set");
    // control in event is logged
    a_ctrl_in_flag: assert property (@(posedge clk) disable iff (sys_rst)
        ctrl_in_event |=> s_q.src[`BIT_CTRL_IN])
        else $error("control in flag not set");
    // control out event is logged
    a_ctrl_out_flag: assert property (@(posedge clk) disable iff (sys_rst)
        ctrl_out_event |=> s_q.src[`BIT_CTRL_OUT])
        else $error("control out flag not set");
    // highest endpoint logged whatever its enable
    a_masked_logged: assert property (@(posedge clk) disable iff (sys_rst)
        ep_event[`NUM_EP-1] |=> s_q.src[`BIT_EP_FIRST + `NUM_EP - 1])
        else $error("masked endpoint event not logged");
    // global disable kills the request
    a_global_gate: assert property (@(posedge clk) disable iff (sys_rst)
        !s_q.global_en |-> !any_req)
        else $error("request passed global disable");
    // pulse pin follows the counter and polarity
    a_pulse_shape: assert property (@(posedge clk) disable iff (sys_rst)
        s_q.pulse_style && $past(s_q.pulse_style) && $stable(s_q.polarity_high)
        |-> irq_out == ((s_q.pulse_cnt != 3'h0) ~^ s_q.polarity_high))
        else $error("pulse output level wrong");
    // no new pulse without a rising request
    a_pulse_once: assert property (@(posedge clk) disable iff (sys_rst)
        s_q.pulse_style && s_q.pulse_cnt == 3'h0 && !(any_req && !s_q.any_prev)
        |=> s_q.pulse_cnt == 3'h0)
        else $error("pulse without rising request");
    // pulse counter never above its load value
    a_pulse_range: assert property (@(posedge clk) disable iff (sys_rst)
        s_q.pulse_cnt <= 3'(`PULSE_CYCLES))
        else $error("pulse counter out of range");
    // status read clears its endpoint flag
    a_ep_cleared: assert property (@(posedge clk) disable iff (sys_rst)
        ep_status_rd[0] && !ep_event[0] |=> !s_q.src[`BIT_EP_FIRST])
        else $error("endpoint flag survived status read");
    // last byte returns the sequencer to idle
    a_read_return: assert property (@(posedge clk) disable iff (sys_rst)
        read_last |=> s_q.rd_state == usb_irq_pkg::RD_IDLE && data_out == 8'h00)
        else $error("read sequencer did not return to idle");
    // a real frame ends the suspend request
    a_sleep_cleared: assert property (@(posedge clk) disable iff (sys_rst)
        frame_seen_pulse |=> !s_q.sleep_req && s_q.missed == 2'h0)
        else $error("frame did not clear suspend request");
    // suspend request only with a full miss count
    a_missed_range: assert property (@(posedge clk) disable iff (sys_rst)
        s_q.sleep_req |-> s_q.missed == `MISSED_FOR_SLEEP)
        else $error("suspend request without missed frames");

endmodule

// [sim/fw_reader.sv]
// firmware side model: reads the interrupt source register over the command port
`include "usb_irq_consts.svh"

module fw_reader (
    // clock
    input wire logic clk,
    // command port
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic data_rd,
    input wire logic [7:0] data_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cmd_valid = 1'b0;
        cmd_code = 8'h3F;
        data_rd = 1'b0;
    end

    // command byte, then all four bytes, low byte first
    task automatic read_sources(output logic [31:0] val);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_code = `CMD_READ_IRQ;
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_code = ~cmd_code; // idle code is never left looking valid
        for (int i = 0; i < 4; i++) begin
            val[8*i +: 8] = data_out;
            data_rd = 1'b1;
            @(negedge clk);
        end
        data_rd = 1'b0;
    endtask
endmodule

// [sim/usb_device_interrupt_logic_test.sv]
// self-checking bench for the usb device interrupt logic
`include "usb_irq_consts.svh"

module usb_device_interrupt_logic_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic clk, sys_rst, cmd_valid, data_rd, enable_wr, mode_wr, hwcfg_wr;
    logic glob, pol, sty, idle, irq_out, bus_sleep_state, sleep_request;
    logic [7:0] cmd_code, data_out;
    logic [31:0] enable_wdata, ev, clr, v, lfsr, m;
    int fail_count, cmp_count, cycles, n;

    usb_irq_logic i_usb_irq_logic (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .data_rd(data_rd), .data_out(data_out),
        .enable_wr(enable_wr), .enable_wdata(enable_wdata), .mode_wr(mode_wr),
        .global_irq_enable(glob), .hwcfg_wr(hwcfg_wr), .irq_polarity_select(pol),
        .irq_signal_style(sty), .ep_event(ev[23:10]), .ep_status_rd(clr[23:10]),
        .ctrl_in_event(ev[9]), .ctrl_out_event(ev[8]), .ctrl_in_status_rd(clr[9]),
        .ctrl_out_status_rd(clr[8]), .frame_seen_pulse(ev[4]),
        .bus_reset_pulse(ev[0]), .resume_pulse(ev[1]), .dma_count_zero(ev[3]),
        .bus_idle_level(idle), .irq_out(irq_out), .bus_sleep_state(bus_sleep_state),
        .sleep_request(sleep_request));

    fw_reader i_fw_reader (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .data_rd(data_rd), .data_out(data_out));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // endpoint and control flags sit at bits 8 to 23
    function automatic logic [31:0] ep_expect(input logic [15:0] f);
        return {8'h00, f, 8'h00};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic fire(input logic [31:0] e);
        @(negedge clk);
        ev = e;
        @(negedge clk);
        ev = '0;
    endtask

    task automatic cfg(input logic [31:0] en, input logic g, input logic p, input logic s);
        @(negedge clk);
        {enable_wr, mode_wr, hwcfg_wr} = 3'h7;
        {enable_wdata, glob, pol, sty} = {en, g, p, s};
        @(negedge clk);
        {enable_wr, mode_wr, hwcfg_wr} = 3'h0;
    endtask

    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // clock and hang guard
    // ---------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // the pseudo frame run needs about 60k cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 95000) begin
            fail_count++;
            $display("mismatch at %0t: timeout", $time);
            complete_run();
        end
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        {enable_wr, mode_wr, hwcfg_wr, glob, pol, sty, idle} = '0;
        {enable_wdata, ev, clr} = '0;
        lfsr = 32'hF294;
        sys_rst = 1'b1;
        repeat (20) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        chk(irq_out, 1);
        i_fw_reader.read_sources(v);
        chk(v, 0);
        // all masked: events still logged, pin stays idle
        cfg(0, 1, 0, 0);
        for (int k = 0; k < 5; k++) if (k != 2) begin
            fire(32'h1 << k);
            @(negedge clk);
            chk(irq_out, 1);
            i_fw_reader.read_sources(v);
            chk(v, 32'h1 << k);
            i_fw_reader.read_sources(v);
            chk(v, 0);
        end
        // random endpoint and control flags survive source reads
        repeat (6) begin
            lfsr = lfsr_next(lfsr);
            fire(ep_expect(lfsr[15:0]));
            i_fw_reader.read_sources(v);
            chk(v, ep_expect(lfsr[15:0]));
            i_fw_reader.read_sources(v);
            chk(v, ep_expect(lfsr[15:0]));
            fire(0);
            @(negedge clk) clr = 32'h00FFFF00;
            @(negedge clk) clr = 0;
            i_fw_reader.read_sources(v);
            chk(v, 0);
        end
        // level style, global gate
        cfg(32'h2, 1, 0, 0);
        fire(32'h2);
        @(negedge clk);
        chk(irq_out, 0);
        cfg(32'h2, 0, 0, 0);
        @(negedge clk);
        chk(irq_out, 1);
        cfg(32'h2, 1, 0, 0);
        i_fw_reader.read_sources(v);
        @(negedge clk);
        chk(irq_out, 1);
        // pulse style, active high: one pulse per rise only
        cfg(32'h2, 1, 1, 1);
        for (int r = 0; r < 2; r++) begin
            n = 0;
            fire(32'h2);
            repeat (12) @(negedge clk) n += int'(irq_out === 1'b1);
            chk(n, (r == 0) ? `PULSE_CYCLES : 0);
        end
        i_fw_reader.read_sources(v);
        // live bus state and sleep entry flag
        @(negedge clk) idle = 1'b1;
        repeat (6) @(negedge clk);
        chk(bus_sleep_state, 1);
        i_fw_reader.read_sources(v);
        chk(v & 32'h84, 32'h84);
        @(negedge clk) idle = 1'b0;
        repeat (6) @(negedge clk);
        i_fw_reader.read_sources(v);
        chk(v[7], 0);
        // pseudo frame ticks and sleep after missed frames
        cfg(32'h20, 1, 0, 0);
        fire(32'h10);
        i_fw_reader.read_sources(v);
        for (n = 0; n < 21000 && irq_out !== 1'b0; n++) @(negedge clk);
        chk(irq_out, 0);
        i_fw_reader.read_sources(v);
        chk(v[5], 1);
        for (n = 0; n < 61000 && sleep_request !== 1'b1; n++) @(negedge clk);
        // bus state follows the request one cycle later
        @(negedge clk);
        chk({sleep_request, bus_sleep_state}, 2'h3);
        complete_run();
    end
endmodule
